/* hdl/return_rotate_sleep_execute.sv */
// Behaviour
// - The return-with-literal op loads its 8-bit literal into the accumulator, flags untouched.
// - The return-with-literal op also pops the stack head into the PC and takes two cycles.
// - The subroutine return pops the stack head into the PC, touches no flag, takes two cycles.
// - The rotate-right op shifts the file register right through the borrow flag, nothing else.
// - The rotate-right op writes the accumulator when the select is 0, else the file register.
// - Sleep clears the watchdog count and its prescaler.
// - Sleep clears the power-down flag and sets the watchdog-expiry flag, and no other flag.
// - After sleep the oscillator is stopped and execution halts until a wake-up event.
// - The literal-minus-accumulator op stores the difference and updates borrow, nibble, zero.
// - The xor-literal op stores accumulator xor literal and updates only the zero flag.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module return_rotate_sleep_execute
   import exec_pkg::*;
   (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        wake_evt,
   output logic             osc_stop,
   output logic             wdog_clear
   );

   exec_state_t     state_q;
   logic [13:0]     instr_q;
   op_kind_t        kind_q;
   logic [7:0]      acc_q;
   logic [4:0]      status_q;
   logic [PC_W-1:0] pc_q;
   logic [6:0]      faddr_q;
   logic [2:0]      sp_q;
   logic [7:0]      wdog_cnt_q;
   logic [7:0]      wdog_pre_q;
   logic            osc_stop_q;
   logic            wdog_clear_q;
   logic            pready_q;
   logic            pslverr_q;
   logic [31:0]     prdata_q;
   logic [7:0]      file_mem [FILE_DEPTH];
   logic [PC_W-1:0] stack_mem [STACK_DEPTH];

   logic            busy;
   logic            exec;
   logic            is_ret;
   logic            dest_f;
   logic            wr_commit;
   logic            rd_hit;
   logic            err_d;
   logic [31:0]     rd_val;
   logic [7:0]      file_rd;
   logic [PC_W-1:0] stack_head;

   exec_alu_if alu_bus ();

   // ------------------------------------------------------------
   // Datapath hookup
   // ------------------------------------------------------------
   assign busy       = (state_q == ST_EXEC) || (state_q == ST_FLUSH);
   assign exec       = (state_q == ST_EXEC);
   assign is_ret     = (kind_q == K_RETLIT) || (kind_q == K_RETURN);
   assign dest_f     = instr_q[7];
   assign file_rd    = file_mem[instr_q[6:0]];
   assign stack_head = stack_mem[sp_q - 3'd1];

   assign alu_bus.kind  = kind_q;
   assign alu_bus.lit   = instr_q[7:0];
   assign alu_bus.acc   = acc_q;
   assign alu_bus.fdata = file_rd;
   assign alu_bus.cin   = status_q[C_BIT];

   exec_alu u_alu (
      .a (alu_bus.alu)
   );

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      case (paddr)
         INSTR_OFF:  rd_val = {18'h00000, instr_q};
         ACC_OFF:    rd_val = {24'h000000, acc_q};
         STATUS_OFF: rd_val = {27'h0000000, status_q};
         PC_OFF:     rd_val = {19'h00000, pc_q};
         FADDR_OFF:  rd_val = {25'h0000000, faddr_q};
         FDATA_OFF:  rd_val = {24'h000000, file_mem[faddr_q]};
         STACK_OFF:  rd_val = {19'h00000, stack_head};
         STATE_OFF:  rd_val = {24'h000000, sp_q, 3'h0, osc_stop_q, busy};
         WDOG_OFF:   rd_val = {16'h0000, wdog_pre_q, wdog_cnt_q};
         default:    rd_hit = 1'b0;
      endcase
      err_d = !rd_hit;
      if (pwrite && (busy || (paddr == STATE_OFF) || (paddr == WDOG_OFF))) begin
         err_d = 1'b1;
      end
      if (pwrite && (paddr == INSTR_OFF) && (state_q != ST_IDLE)) begin
         err_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (psel && penable && !pready_q) begin
         pready_q  <= 1'b1;
         pslverr_q <= err_d;
         prdata_q  <= pwrite ? 32'h0000_0000 : rd_val;
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   assign wr_commit = psel && penable && pready_q && pwrite && !pslverr_q;

   // ------------------------------------------------------------
   // Instruction latch and sequencing
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         instr_q <= 14'h0000;
         kind_q  <= K_NOP;
      end else if (wr_commit && (paddr == INSTR_OFF)) begin
         instr_q <= pwdata[13:0];
         kind_q  <= decode_op(pwdata[13:0]);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q    <= ST_IDLE;
         osc_stop_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (wr_commit && (paddr == INSTR_OFF)) begin
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (is_ret) begin
                  state_q <= ST_FLUSH;
               end else if (kind_q == K_SLEEP) begin
                  state_q    <= ST_SLEEP;
                  osc_stop_q <= 1'b1;
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            ST_FLUSH: begin
               state_q <= ST_IDLE;
            end
            ST_SLEEP: begin
               if (wake_evt) begin
                  state_q    <= ST_IDLE;
                  osc_stop_q <= 1'b0;
               end
            end
            default: begin
               state_q    <= ST_IDLE;
               osc_stop_q <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Accumulator and status
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         acc_q <= ACC_RST;
      end else if (exec && (kind_q == K_RETLIT || kind_q == K_LITSUB || kind_q == K_XORLIT)) begin
         acc_q <= alu_bus.res;
      end else if (exec && kind_q == K_ROTR && !dest_f) begin
         acc_q <= alu_bus.res;
      end else if (wr_commit && paddr == ACC_OFF) begin
         acc_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         status_q <= STATUS_RST;
      end else if (exec) begin
         case (kind_q)
            K_ROTR: begin
               status_q[C_BIT] <= alu_bus.cout;
            end
            K_LITSUB: begin
               status_q[C_BIT]   <= alu_bus.cout;
               status_q[NIB_BIT] <= alu_bus.dcout;
               status_q[Z_BIT]   <= alu_bus.zout;
            end
            K_XORLIT: begin
               status_q[Z_BIT] <= alu_bus.zout;
            end
            K_SLEEP: begin
               status_q[PWRDN_BIT]  <= 1'b0;
               status_q[EXPIRY_BIT] <= 1'b1;
            end
            default: begin
               status_q <= status_q;
            end
         endcase
      end else if (wr_commit && paddr == STATUS_OFF) begin
         status_q <= pwdata[4:0];
      end
   end

   // ------------------------------------------------------------
   // Program counter, stack and file registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pc_q <= PC_RST;
         sp_q <= 3'h0;
      end else if (exec && is_ret) begin
         pc_q <= stack_head;
         sp_q <= sp_q - 3'd1;
      end else if (exec) begin
         pc_q <= pc_q + 13'h0001;
      end else if (wr_commit && paddr == PC_OFF) begin
         pc_q <= pwdata[PC_W-1:0];
      end else if (wr_commit && paddr == STACK_OFF) begin
         sp_q <= sp_q + 3'd1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (wr_commit && paddr == STACK_OFF) begin
         stack_mem[sp_q] <= pwdata[PC_W-1:0];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         faddr_q <= 7'h00;
      end else if (wr_commit && paddr == FADDR_OFF) begin
         faddr_q <= pwdata[6:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (exec && kind_q == K_ROTR && dest_f) begin
         file_mem[instr_q[6:0]] <= alu_bus.res;
      end else if (wr_commit && paddr == FDATA_OFF) begin
         file_mem[faddr_q] <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // Watchdog count and prescaler
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wdog_cnt_q   <= WDOG_RST;
         wdog_pre_q   <= WDOG_RST;
         wdog_clear_q <= 1'b0;
      end else if (exec && kind_q == K_SLEEP) begin
         wdog_cnt_q   <= WDOG_RST;
         wdog_pre_q   <= WDOG_RST;
         wdog_clear_q <= 1'b1;
      end else begin
         wdog_pre_q   <= wdog_pre_q + 8'h01;
         wdog_clear_q <= 1'b0;
         if (wdog_pre_q == PRE_LAST) begin
            wdog_cnt_q <= wdog_cnt_q + 8'h01;
         end
      end
   end

   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;
   assign osc_stop   = osc_stop_q;
   assign wdog_clear = wdog_clear_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   property p_retlit_acc;
      exec && kind_q == K_RETLIT |=> acc_q == $past(instr_q[7:0]) && status_q == $past(status_q);
   endproperty
   a_retlit_acc: assert property (p_retlit_acc) else $error("Literal return bad.");

   property p_ret_two_cycles;
      exec && is_ret |=> state_q == ST_FLUSH ##1 state_q == ST_IDLE;
   endproperty
   a_ret_two_cycles: assert property (p_ret_two_cycles) else $error("Return length.");

   property p_ret_pop;
      exec && kind_q == K_RETURN
      |=> pc_q == $past(stack_head) && sp_q == $past(sp_q) - 3'd1 && $stable(status_q);
   endproperty
   a_ret_pop: assert property (p_ret_pop) else $error("Return pop bad.");

   property p_rotr_flag;
      exec && kind_q == K_ROTR
      |=> status_q[C_BIT] == $past(file_rd[0]) && status_q[4:1] == $past(status_q[4:1]);
   endproperty
   a_rotr_flag: assert property (p_rotr_flag) else $error("Rotate flag bad.");

   property p_rotr_acc;
      exec && kind_q == K_ROTR && !dest_f
      |=> acc_q == {$past(status_q[C_BIT]), $past(file_rd[7:1])};
   endproperty
   a_rotr_acc: assert property (p_rotr_acc) else $error("Rotate result bad.");

   property p_sleep_wdog;
      exec && kind_q == K_SLEEP |=> wdog_cnt_q == 8'h00 && wdog_pre_q == 8'h00 && wdog_clear_q;
   endproperty
   a_sleep_wdog: assert property (p_sleep_wdog) else $error("Watchdog not cleared.");

   property p_sleep_flags;
      exec && kind_q == K_SLEEP
      |=> !status_q[PWRDN_BIT] && status_q[EXPIRY_BIT] && status_q[2:0] == $past(status_q[2:0]);
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) else $error("Sleep flags bad.");

   property p_sleep_hold;
      state_q == ST_SLEEP && !wake_evt |=> state_q == ST_SLEEP && osc_stop_q && $stable(pc_q);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("Sleep left early.");

   property p_sub;
      exec && kind_q == K_LITSUB
      |=> acc_q == 8'($past(instr_q[7:0]) - $past(acc_q))
          && status_q[C_BIT] == ($past(instr_q[7:0]) >= $past(acc_q))
          && status_q[Z_BIT] == (acc_q == 8'h00);
   endproperty
   a_sub: assert property (p_sub) else $error("Subtract bad.");

   property p_sub_nibble;
      exec && kind_q == K_LITSUB
      |=> status_q[NIB_BIT] == ($past(instr_q[3:0]) >= $past(acc_q[3:0]));
   endproperty
   a_sub_nibble: assert property (p_sub_nibble) else $error("Nibble flag bad.");

   property p_xor;
      exec && kind_q == K_XORLIT
      |=> acc_q == ($past(acc_q) ^ $past(instr_q[7:0])) && status_q[Z_BIT] == (acc_q == 8'h00)
          && status_q[1:0] == $past(status_q[1:0]) && status_q[4:3] == $past(status_q[4:3]);
   endproperty
   a_xor: assert property (p_xor) else $error("Xor bad.");

   c_retlit: cover property (exec && kind_q == K_RETLIT ##2 state_q == ST_IDLE);
   c_wake: cover property (state_q == ST_SLEEP ##1 wake_evt ##1 state_q == ST_IDLE);
   c_borrow: cover property (exec && kind_q == K_LITSUB ##1 !status_q[C_BIT]);

endmodule
`default_nettype wire

/* inc/exec_pkg.sv */
`default_nettype none
package exec_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int PC_W        = 13;
   localparam int STACK_DEPTH = 8;
   localparam int FILE_DEPTH  = 128;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] INSTR_OFF  = 8'h00;
   localparam logic [7:0] ACC_OFF    = 8'h04;
   localparam logic [7:0] STATUS_OFF = 8'h08;
   localparam logic [7:0] PC_OFF     = 8'h0C;
   localparam logic [7:0] FADDR_OFF  = 8'h10;
   localparam logic [7:0] FDATA_OFF  = 8'h14;
   localparam logic [7:0] STACK_OFF  = 8'h18;
   localparam logic [7:0] STATE_OFF  = 8'h1C;
   localparam logic [7:0] WDOG_OFF   = 8'h20;

   // ------------------------------------------------------------
   // Status bits and reset values
   // ------------------------------------------------------------
   localparam int C_BIT  = 0;
   localparam int NIB_BIT    = 1;
   localparam int Z_BIT      = 2;
   localparam int PWRDN_BIT  = 3;
   localparam int EXPIRY_BIT = 4;
   localparam logic [4:0]      STATUS_RST = 5'h18;
   localparam logic [7:0]      ACC_RST    = 8'h00;
   localparam logic [PC_W-1:0] PC_RST     = 13'h0000;
   localparam logic [7:0]      WDOG_RST   = 8'h00;
   localparam logic [7:0]      PRE_LAST   = 8'hFF;

   // ------------------------------------------------------------
   // Opcode masks and patterns
   // ------------------------------------------------------------
   localparam logic [13:0] RETLIT_MASK = 14'h3C00;
   localparam logic [13:0] RETLIT_PAT  = 14'h3400;
   localparam logic [13:0] LITSUB_MASK = 14'h3E00;
   localparam logic [13:0] LITSUB_PAT  = 14'h3C00;
   localparam logic [13:0] XORLIT_MASK = 14'h3F00;
   localparam logic [13:0] XORLIT_PAT  = 14'h3A00;
   localparam logic [13:0] ROTR_MASK   = 14'h3F00;
   localparam logic [13:0] ROTR_PAT    = 14'h0C00;
   localparam logic [13:0] RET_CODE    = 14'h0008;
   localparam logic [13:0] SLEEP_CODE  = 14'h0063;

   typedef enum logic [2:0] {
      K_NOP, K_RETLIT, K_ROTR, K_RETURN, K_SLEEP, K_LITSUB, K_XORLIT
   } op_kind_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_EXEC  = 4'b0010,
      ST_FLUSH = 4'b0100,
      ST_SLEEP = 4'b1000
   } exec_state_t;

   function automatic op_kind_t decode_op(input logic [13:0] op);
      if ((op & RETLIT_MASK) == RETLIT_PAT) return K_RETLIT;
      if ((op & LITSUB_MASK) == LITSUB_PAT) return K_LITSUB;
      if ((op & XORLIT_MASK) == XORLIT_PAT) return K_XORLIT;
      if ((op & ROTR_MASK) == ROTR_PAT) return K_ROTR;
      if (op == RET_CODE) return K_RETURN;
      if (op == SLEEP_CODE) return K_SLEEP;
      return K_NOP;
   endfunction

endpackage
`default_nettype wire

/* inc/exec_alu_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface exec_alu_if
   import exec_pkg::*;
   ();
   op_kind_t   kind;
   logic [7:0] lit;
   logic [7:0] acc;
   logic [7:0] fdata;
   logic       cin;
   logic [7:0] res;
   logic       cout;
   logic       dcout;
   logic       zout;

   modport core (output kind, lit, acc, fdata, cin, input res, cout, dcout, zout);
   modport alu  (input kind, lit, acc, fdata, cin, output res, cout, dcout, zout);
endinterface
`default_nettype wire

/* hdl/exec_alu.sv */
`timescale 1ns/1ns
`default_nettype none
module exec_alu
   import exec_pkg::*;
   (
   exec_alu_if.alu a
   );

   logic [8:0] diff;

   // ------------------------------------------------------------
   // Result and flag arithmetic
   // ------------------------------------------------------------
   always_comb begin
      diff    = {1'b0, a.lit} + {1'b0, ~a.acc} + 9'h001;
      a.res   = a.acc;
      a.cout  = a.cin;
      a.dcout = 1'b0;
      case (a.kind)
         K_RETLIT: begin
            a.res = a.lit;
         end
         K_ROTR: begin
            a.res  = {a.cin, a.fdata[7:1]};
            a.cout = a.fdata[0];
         end
         K_LITSUB: begin
            a.res   = diff[7:0];
            a.cout  = diff[8];
            a.dcout = (a.lit[3:0] >= a.acc[3:0]);
         end
         K_XORLIT: begin
            a.res = a.acc ^ a.lit;
         end
         default: begin
            a.res = a.acc;
         end
      endcase
      a.zout = (a.res == 8'h00);
   end

endmodule
`default_nettype wire

/* verification/wake_source.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Wake-up source and watchdog clear monitor
// ------------------------------------------------------------
module wake_source (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       osc_stop,
   input  wire logic       wdog_clear,
   input  wire logic [7:0] wake_delay,
   output logic            wake_evt,
   output logic      [7:0] n_clear
   );
   logic [7:0] stop_cnt_q;

   // Counts clear pulses and raises wake only after the oscillator stayed stopped a while.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stop_cnt_q <= 8'h00;
         wake_evt   <= 1'b0;
         n_clear    <= 8'h00;
      end else begin
         if (wdog_clear) n_clear <= n_clear + 8'h01;
         stop_cnt_q <= osc_stop ? stop_cnt_q + 8'h01 : 8'h00;
         wake_evt   <= osc_stop && (stop_cnt_q >= wake_delay);
      end
   end
endmodule
`default_nettype wire

/* verification/return_rotate_sleep_execute_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module return_rotate_sleep_execute_tb;
   import exec_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0;
   logic [31:0] prdata, r;
   logic        pready, pslverr, osc_stop, wdog_clear, wake_evt, err;
   logic [7:0]  n_clear, a, k, st, fv, res;
   int          n_mismatch = 0;
   int          tests_run  = 0;
   logic [7:0]  sa[5] = '{8'h03, 8'h01, 8'h05, 8'h42, 8'h10};
   logic [7:0]  sk[5] = '{8'h05, 8'h10, 8'h03, 8'h42, 8'h01};

   always #20 core_clk = ~core_clk;

   return_rotate_sleep_execute dut (.core_clk(core_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wake_evt(wake_evt), .osc_stop(osc_stop),
      .wdog_clear(wdog_clear));
   wake_source far (.core_clk(core_clk), .rst(rst), .osc_stop(osc_stop),
      .wdog_clear(wdog_clear), .wake_delay(8'h3C), .wake_evt(wake_evt), .n_clear(n_clear));

   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   task automatic complete_run;
      $display("Counts: %0d compares, %0d mismatches", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n = 0;
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 16);
      r = prdata;
      err = pslverr;
      if (n >= 16) chk(32'h0, 32'h1, "no bus answer");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
   endtask

   task automatic rd(input logic [7:0] ad);
      apb(1'b0, ad, 32'h0);
   endtask

   task automatic op(input logic [13:0] o);
      int n = 0;
      wr(INSTR_OFF, {18'h0, o});
      chk({31'h0, err}, 32'h0, "instruction refused");
      do begin rd(STATE_OFF); n++; end while (r[1:0] !== 2'b00 && n < 8);
      chk({30'h0, r[1:0]}, 32'h0, "instruction still running");
   endtask

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rd(ACC_OFF);    chk(r, {24'h0, ACC_RST}, "acc reset");
      rd(STATUS_OFF); chk(r, {27'h0, STATUS_RST}, "status reset");
      rd(PC_OFF);     chk(r, {19'h0, PC_RST}, "pc reset");
      rd(8'h24);      chk({31'h0, err}, 32'h1, "unmapped read");
      wr(WDOG_OFF, 32'h0); chk({31'h0, err}, 32'h1, "read-only write");
      $display("test reset done");
      for (int i = 0; i < 2; i++) begin
         k  = i ? 8'hFF : 8'h00;
         st = i ? 8'h07 : 8'h1A;
         wr(STACK_OFF, 32'h123 + i);
         wr(STATUS_OFF, {24'h0, st});
         op(RETLIT_PAT | (i ? 14'h0300 : 14'h0000) | {6'h0, k});
         rd(ACC_OFF);    chk(r, {24'h0, k}, "literal return acc");
         rd(STATUS_OFF); chk(r, {24'h0, st}, "literal return flags");
         rd(PC_OFF);     chk(r, 32'h123 + i, "literal return pc");
      end
      wr(STACK_OFF, 32'h456);
      wr(STATUS_OFF, 32'h05);
      op(RET_CODE);
      rd(PC_OFF);     chk(r, 32'h456, "return pc");
      rd(STATUS_OFF); chk(r, 32'h05, "return flags");
      $display("test returns done");
      for (int d = 0; d < 2; d++) begin
         a  = d ? 8'h7F : 8'h00;
         st = d ? 8'h1E : 8'h07;
         fv = 8'h81;
         wr(FADDR_OFF, {24'h0, a});
         wr(FDATA_OFF, {24'h0, fv});
         wr(ACC_OFF, 32'h3C);
         wr(STATUS_OFF, {24'h0, st});
         op(ROTR_PAT | (d ? 14'h0080 : 14'h0000) | {6'h0, a});
         res = {st[0], fv[7:1]};
         rd(ACC_OFF);    chk(r, d ? 32'h3C : {24'h0, res}, "rotate acc");
         rd(FDATA_OFF);  chk(r, d ? {24'h0, res} : {24'h0, fv}, "rotate file");
         rd(STATUS_OFF); chk(r, {24'h0, st[7:1], fv[0]}, "rotate flags");
      end
      $display("test rotate done");
      for (int i = 0; i < 5; i++) begin
         st  = i[0] ? 8'h1F : 8'h18;
         res = sk[i] - sa[i];
         wr(STATUS_OFF, {24'h0, st});
         wr(ACC_OFF, {24'h0, sa[i]});
         op(LITSUB_PAT | (i[0] ? 14'h0100 : 14'h0000) | {6'h0, sk[i]});
         fv = {3'h0, st[4:3], res == 8'h00, sk[i][3:0] >= sa[i][3:0], sk[i] >= sa[i]};
         rd(ACC_OFF); chk(r, {24'h0, res}, "subtract result");
         rd(STATUS_OFF); chk(r, {24'h0, fv}, "subtract flags");
      end
      $display("test subtract done");
      for (int i = 0; i < 2; i++) begin
         a  = i ? 8'h0F : 8'h5A;
         k  = i ? 8'hF0 : 8'h5A;
         st = i ? 8'h1F : 8'h1B;
         wr(STATUS_OFF, {24'h0, st});
         wr(ACC_OFF, {24'h0, a});
         op(XORLIT_PAT | {6'h0, k});
         rd(ACC_OFF); chk(r, {24'h0, a ^ k}, "xor result");
         rd(STATUS_OFF); chk(r, {27'h0, st[4:3], (a ^ k) == 8'h00, st[1:0]}, "xor flags");
      end
      $display("test xor done");
      wr(STATUS_OFF, 32'h0F);
      wr(INSTR_OFF, {18'h0, SLEEP_CODE}); chk({31'h0, err}, 32'h0, "sleep refused");
      rd(STATE_OFF);  chk({31'h0, r[1]}, 32'h1, "sleeping");
      chk({31'h0, osc_stop}, 32'h1, "oscillator stopped");
      rd(STATUS_OFF); chk(r, 32'h17, "sleep flags");
      rd(WDOG_OFF);   chk({24'h0, r[7:0]}, 32'h0, "watchdog count");
      chk({31'h0, r[15:8] < 8'h20}, 32'h1, "prescaler cleared");
      wr(INSTR_OFF, 32'h0); chk({31'h0, err}, 32'h1, "op while asleep");
      rd(STATE_OFF);
      for (int n = 0; n < 40 && r[1] !== 1'b0; n++) rd(STATE_OFF);
      @(posedge core_clk);
      chk({31'h0, osc_stop}, 32'h0, "woken");
      chk({24'h0, n_clear}, 32'h1, "watchdog clear pulses");
      $display("test sleep done");
      complete_run();
   end

   initial begin
      #(40 * 5000);
      n_mismatch++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      complete_run();
   end
endmodule
`default_nettype wire
